// >>> hw/flr_pkg.sv
// Shared constants for the function-level reset handshake
package flr_pkg;
    // Application clock, either 125 or 250 MHz
    localparam int APP_CLK_MHZ_LOW = 125;
    localparam int APP_CLK_MHZ_HIGH = 250;
    localparam int APP_CLK_MHZ = APP_CLK_MHZ_LOW;
    // Device control register reset field position
    localparam int DEVCTL_RESET_BIT = 15;
    // Physical function count in the reduced configuration
    localparam int NUM_PF = 2;
    // Virtual function count and its index width
    localparam int NUM_VF = 64;
    localparam int VF_W = $clog2(NUM_VF);
    // Deadline for the application answer, microseconds
    localparam int RESET_DEADLINE_US = 100;
    localparam int RESET_DEADLINE_CYC = RESET_DEADLINE_US * APP_CLK_MHZ;
    // Default application work time in cycles
    localparam int APP_WORK_CYC = 16;
endpackage

// >>> hw/flr_if.sv
// Interface joining the bridge end and the application end
`timescale 1ns/1ps
interface flr_if #(
    parameter int NPF = 2,
    parameter int VFW = 6
) (
    input wire logic clk,
    input wire logic rst
);
    logic [NPF-1:0] pf_reset_active;
    logic [NPF-1:0] pf_reset_done;
    logic vf_reset_request;
    logic [NPF-1:0] vf_reset_owner_pf;
    logic [VFW-1:0] vf_reset_offset;
    logic vf_reset_complete;
    logic [NPF-1:0] vf_complete_owner_pf;
    logic [VFW-1:0] vf_complete_index;

    modport bridge (
        input clk, rst, pf_reset_done, vf_reset_complete,
        input vf_complete_owner_pf, vf_complete_index,
        output pf_reset_active, vf_reset_request,
        output vf_reset_owner_pf, vf_reset_offset
    );
    modport app (
        input clk, rst, pf_reset_active, vf_reset_request,
        input vf_reset_owner_pf, vf_reset_offset,
        output pf_reset_done, vf_reset_complete,
        output vf_complete_owner_pf, vf_complete_index
    );
endinterface

// >>> hw/flr_app.sv
// Application end: clears function work and answers resets
`timescale 1ns/1ps
module flr_app
    import flr_pkg::*;
#(
    parameter int NPF = NUM_PF,
    parameter int VFW = VF_W,
    parameter int WORK_CYC = APP_WORK_CYC
) (
    flr_if.app link,
    // Pending-work indication per PF, plus one bit for the VF in work
    output logic [NPF-1:0] pf_flush,
    output logic vf_flush,
    // Completion report toward user logic
    output logic [VFW-1:0] vf_last_done
);
    typedef enum logic [1:0] {
        A_IDLE = 2'b00,
        A_WORK = 2'b01,
        A_DONE = 2'b11
    } vst_t;

    typedef struct packed {
        logic [NPF-1:0] pf_busy;
        logic [NPF-1:0] pf_done;
        logic [15:0] pf_cnt;
        vst_t vst;
        logic [15:0] vcnt;
        logic [NPF-1:0] vpf;
        logic [VFW-1:0] vnum;
        logic vcomp;
        logic [VFW-1:0] last;
    } st_t;

    st_t s_r, s_nxt;

    // All PFs active at pickup are served together; done pulses one cycle per PF
    always_comb begin
        s_nxt = s_r;
        s_nxt.pf_done = '0;
        s_nxt.vcomp = 1'b0;
        if (s_r.pf_busy == '0) begin
            // Watch the active line; the cfg bus decode is outside
            s_nxt.pf_busy = link.pf_reset_active & ~s_r.pf_done;
            s_nxt.pf_cnt = 16'(WORK_CYC);
        end else if (s_r.pf_cnt != 16'h0000) begin
            s_nxt.pf_cnt = s_r.pf_cnt - 16'h0001; // flush
        end else begin
            s_nxt.pf_done = s_r.pf_busy;
            s_nxt.pf_busy = '0;
        end
        unique case (s_r.vst)
            A_IDLE: begin
                if (link.vf_reset_request) begin
                    s_nxt.vpf = link.vf_reset_owner_pf;
                    s_nxt.vnum = link.vf_reset_offset;
                    s_nxt.vcnt = 16'(WORK_CYC);
                    s_nxt.vst = A_WORK;
                end
            end
            A_WORK: begin
                // Short work keeps well inside the deadline
                if (s_r.vcnt == 16'h0000) begin
                    s_nxt.vst = A_DONE;
                    s_nxt.vcomp = 1'b1;
                end else begin
                    s_nxt.vcnt = s_r.vcnt - 16'h0001;
                end
            end
            A_DONE: begin
                s_nxt.last = s_r.vnum;
                s_nxt.vst = A_IDLE;
            end
            default: s_nxt.vst = A_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge link.clk or posedge link.rst) begin
        if (link.rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.pf_reset_done = s_r.pf_done;
    assign link.vf_reset_complete = s_r.vcomp;
    assign link.vf_complete_owner_pf = s_r.vpf;
    assign link.vf_complete_index = s_r.vnum;
    assign pf_flush = s_r.pf_busy;
    assign vf_flush = (s_r.vst == A_WORK);
    assign vf_last_done = s_r.last;
endmodule

// >>> hw/flr_bridge.sv
// Bridge end: raises function resets and tracks completion
`timescale 1ns/1ps
module flr_bridge
    import flr_pkg::*;
#(
    parameter int NPF = NUM_PF,
    parameter int VFW = VF_W,
    parameter int DEADLINE = RESET_DEADLINE_CYC
) (
    flr_if.bridge link,
    // Device control register writes
    input wire logic cfg_wr,
    input wire logic cfg_is_vf,
    input wire logic [NPF-1:0] cfg_pf,
    input wire logic [VFW-1:0] cfg_vf,
    input wire logic [15:0] cfg_data,
    // Function re-enable and status
    output logic [NPF-1:0] pf_enabled,
    output logic [NPF-1:0] pf_late,
    output logic vf_late,
    output logic vf_done_seen,
    output logic [NPF-1:0] vf_done_pf,
    output logic [VFW-1:0] vf_done_index
);
    typedef struct packed {
        logic [NPF-1:0] act;
        logic [NPF-1:0] en;
        logic [NPF-1:0] late;
        logic [NPF-1:0][31:0] cnt;
        logic req;
        logic [NPF-1:0] rpf;
        logic [VFW-1:0] rvf;
        logic vwait;
        logic [31:0] vcnt;
        logic vlate;
        logic vseen;
        logic [NPF-1:0] dpf;
        logic [VFW-1:0] dvf;
    } st_t;

    st_t s_r, s_nxt;
    logic hit;

    // Single clock domain for every port
    assign hit = cfg_wr & cfg_data[DEVCTL_RESET_BIT];

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.req = 1'b0;
        s_nxt.vseen = 1'b0;
        // PF tracking, one bit per function
        for (int i = 0; i < NPF; i++) begin
            if (s_r.act[i]) begin
                if (link.pf_reset_done[i]) begin
                    s_nxt.act[i] = 1'b0;
                    s_nxt.en[i] = 1'b1;
                end else if (s_r.cnt[i] != 32'h0000_0000) begin
                    s_nxt.cnt[i] = s_r.cnt[i] - 32'h0000_0001;
                end else begin
                    s_nxt.late[i] = 1'b1; // Watch deadline
                end
            end
            // A new write wins over a same-cycle done
            if (hit && !cfg_is_vf && cfg_pf == NPF'(i)) begin
                s_nxt.act[i] = 1'b1;
                s_nxt.en[i] = 1'b0;
                s_nxt.late[i] = 1'b0;
                s_nxt.cnt[i] = 32'(DEADLINE);
            end
        end
        // VF completion tracking
        if (link.vf_reset_complete) begin
            s_nxt.vwait = 1'b0;
            s_nxt.vseen = 1'b1;
            s_nxt.dpf = link.vf_complete_owner_pf;
            s_nxt.dvf = link.vf_complete_index;
        end else if (s_r.vwait) begin
            if (s_r.vcnt != 32'h0000_0000) begin
                s_nxt.vcnt = s_r.vcnt - 32'h0000_0001;
            end else begin
                s_nxt.vlate = 1'b1;
            end
        end
        if (hit && cfg_is_vf) begin
            s_nxt.req = 1'b1; // One-cycle pulse
            s_nxt.rpf = cfg_pf;
            s_nxt.rvf = cfg_vf;
            s_nxt.vwait = 1'b1;
            s_nxt.vlate = 1'b0;
            s_nxt.vcnt = 32'(DEADLINE);
        end
    end

    // State register
    always_ff @(posedge link.clk or posedge link.rst) begin
        if (link.rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.pf_reset_active = s_r.act;
    assign link.vf_reset_request = s_r.req;
    assign link.vf_reset_owner_pf = s_r.rpf;
    assign link.vf_reset_offset = s_r.rvf;
    assign pf_enabled = s_r.en;
    assign pf_late = s_r.late;
    assign vf_late = s_r.vlate;
    assign vf_done_seen = s_r.vseen;
    assign vf_done_pf = s_r.dpf;
    assign vf_done_index = s_r.dvf;
endmodule

// >>> verification/flr_sva.sv
// Timing checks on the wires between bridge and application
`timescale 1ns/1ps
module flr_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bridge to application
    input wire logic [1:0] pf_reset_active,
    input wire logic vf_reset_request,
    input wire logic [1:0] vf_reset_owner_pf,
    input wire logic [5:0] vf_reset_offset,
    // Application to bridge
    input wire logic [1:0] pf_reset_done,
    input wire logic vf_reset_complete,
    input wire logic [1:0] vf_complete_owner_pf,
    input wire logic [5:0] vf_complete_index
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Bench work time is short, so the answer bound stays small
    localparam int LIM = 60;
    sequence s_req;
        vf_reset_request ##1 !vf_reset_request;
    endsequence
    a_req_pulse: assert property (s_req or !vf_reset_request)
        else $error("vf request longer than one cycle");
    a_req_fields: assert property (s_req |->
        $stable({vf_reset_owner_pf, vf_reset_offset}))
        else $error("vf request fields moved");
    a_vf_answer: assert property (vf_reset_request |->
        ##[2:LIM] vf_reset_complete) else $error("vf complete missing");
    a_vf_echo: assert property (vf_reset_complete |->
        {vf_complete_owner_pf, vf_complete_index} ==
        {vf_reset_owner_pf, vf_reset_offset}) else $error("vf echo wrong");
    // One set of checks per function bit
    for (genvar i = 0; i < 2; i++) begin : g_pf
        a_pf_hold: assert property (pf_reset_active[i] &&
            !pf_reset_done[i] |=> pf_reset_active[i])
            else $error("pf active dropped early");
        a_pf_clear: assert property (pf_reset_done[i] |=>
            !pf_reset_active[i]) else $error("pf active not cleared");
        a_pf_answer: assert property ($rose(pf_reset_active[i]) |->
            ##[2:LIM] pf_reset_done[i]) else $error("pf done missing");
        a_done_pulse: assert property (pf_reset_done[i] |->
            pf_reset_active[i] ##1 !pf_reset_done[i])
            else $error("pf done without active");
    end
endmodule

// >>> verification/function_level_reset_handshake_tb.sv
// Bench joining bridge and application, checking reported results
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    bad_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module function_level_reset_handshake_tb;
    logic clk = 0;
    logic rst = 1;
    logic cfg_wr = 0, cfg_is_vf = 0;
    logic [1:0] cfg_pf = 0, en, en_q = 0, pfl, fl, vpf;
    logic [5:0] cfg_vf = 0, vidx, vlast;
    logic [15:0] cfg_data = 0;
    logic vlate, vseen, vfl;
    logic [31:0] lfsr = 32'hA53D8CBF;
    logic [8:0] q[$];
    int bad_count = 0, check_count = 0;
    // Clock at 50 ns period
    initial forever #25 clk = ~clk; // One clock for both ends
    flr_if #(.NPF(2), .VFW(6)) link (.clk(clk), .rst(rst));
    flr_bridge #(.DEADLINE(50)) i_flr_bridge (.link(link),
        .cfg_wr(cfg_wr), .cfg_is_vf(cfg_is_vf), .cfg_pf(cfg_pf),
        .cfg_vf(cfg_vf), .cfg_data(cfg_data), .pf_enabled(en),
        .pf_late(pfl), .vf_late(vlate), .vf_done_seen(vseen),
        .vf_done_pf(vpf), .vf_done_index(vidx));
    flr_app i_flr_app (.link(link), .pf_flush(fl), .vf_flush(vfl),
        .vf_last_done(vlast));
    flr_sva i_flr_sva (.clk(clk), .rst(rst),
        .pf_reset_active(link.pf_reset_active),
        .vf_reset_request(link.vf_reset_request),
        .vf_reset_owner_pf(link.vf_reset_owner_pf),
        .vf_reset_offset(link.vf_reset_offset),
        .pf_reset_done(link.pf_reset_done),
        .vf_reset_complete(link.vf_reset_complete),
        .vf_complete_owner_pf(link.vf_complete_owner_pf),
        .vf_complete_index(link.vf_complete_index));
    task results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Next random word for the stimulus
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Device control write; only bit 15 set expects a result
    // Bench knows the target from its own write
    task wr(input logic vf, input logic [1:0] p, input logic [15:0] d);
        @(negedge clk);
        lfsr = lfsr_next(lfsr);
        {cfg_wr, cfg_is_vf, cfg_pf, cfg_vf, cfg_data} = {1'b1, vf, p,
            lfsr[13:8], d};
        if (d[15]) q.push_back(vf ? {1'b1, p, lfsr[13:8]} : {7'h0, p});
        @(negedge clk);
        cfg_wr = 0;
    endtask
    // Bounded wait until every noted result has shown up
    task drain(input string t);
        for (int k = 0; k < 200 && q.size() != 0; k++) @(negedge clk);
        `CHK("pending", 0, q.size())
        `CHK("flush", 3'h0, {fl, vfl}) // Work cleared
        $display("test %s done", t);
    endtask
    // Watch results: VF completions and PF re-enables, oldest note first
    always @(negedge clk) begin
        logic [8:0] e;
        logic [8:0] seen;
        for (int i = 0; i < 3; i++) begin
            if (i == 2 ? vseen : en[i] && !en_q[i]) begin
                e = q.size() ? q.pop_front() : 9'h1FF;
                seen = i == 2 ? {1'b1, vpf, vidx} : {7'h0, i[1:0]};
                `CHK("result", e, seen)
                if (i == 2) begin
                    `CHK("last", e[5:0], vlast)
                end
            end
        end
        en_q = en;
    end
    // Hang guard, well beyond the expected run
    initial begin
        #(50 * 20000);
        bad_count++;
        results;
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 0;
        for (int p = 0; p < 2; p++) begin
            wr(0, p[1:0], 16'h8000);
            drain("pf single");
        end
        wr(0, 2'h0, 16'h8000);
        wr(0, 2'h1, 16'hFFFF);
        drain("pf batch");
        repeat (6) begin
            wr(1, {1'b0, lfsr[0]}, 16'h8000 | lfsr[15:0]);
            drain("vf");
        end
        wr(0, 2'h1, lfsr[15:0] & 16'h7FFF);
        wr(1, 2'h0, 16'h7FFF);
        repeat (40) @(negedge clk);
        `CHK("late", 3'h0, {pfl, vlate})
        drain("no reset");
        results;
    end
endmodule
